// file: shared/scan_regs.svh
// Register offsets, field positions, reset values and timing for the scanner.
`ifndef SCAN_REGS_SVH
`define SCAN_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_TIMER_CTRL 8'h00
`define OFS_CLOCK_SEL 8'h04
`define OFS_CLOCK_DIV 8'h08
`define OFS_COMPARE 8'h0C
`define OFS_MATCH_STATUS 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_ENABLE 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_CLOCK_MODE 8'h20
`define OFS_ALARM_CTRL 8'h24
`define OFS_TIME 8'h28
`define OFS_SEG_BASE 8'h40

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GATE_BIT 0
`define MODE32_BIT 6
`define SEL_HIGH_SPEED_OSC 8'h01
`define COMPARE_RESET 32'h0000F9FF
`define IRQ_TIMER_BIT 0
`define IRQ_CLOCK_BIT 1
`define IRQ_ALARM_BIT 2
`define CLOCK_PERIOD_1S 3'h2
`define CLOCK_24H_BIT 3
`define ALARM_EN_BIT 7
`define DIGIT_SEL_INIT 4'h7
`define DIGIT_ALL_OFF 4'hF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ 250
`define BLANK_NS 1000
`define SETTLE_NS 500
`define SECOND_CYCLES 250000000

`endif

// file: shared/scan_pkg.sv
// Types shared by the seven-segment scan controller.
`default_nettype none
package scan_pkg;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h0,
      SEQ_CLEAR = 3'h1,
      SEQ_BLANK = 3'h3,
      SEQ_DATA = 3'h2,
      SEQ_SETTLE = 3'h6,
      SEQ_SELECT = 3'h7
   } seq_state_t;

   typedef struct packed {
      logic pm;
      logic [3:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
   } clock_time_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } bus_out_t;

   typedef struct packed {
      bus_out_t bus;
      logic [7:0] timer_ctrl;
      logic [7:0] clock_sel;
      logic [3:0] clock_div;
      logic [31:0] compare;
      logic match_status;
      logic [2:0] irq_status;
      logic [2:0] irq_enable;
      logic [1:0] irq_mask;
      logic [7:0] clock_mode;
      logic [7:0] alarm_ctrl;
      clock_time_t now;
      logic [27:0] sec_count;
      logic [15:0] pre_count;
      logic [31:0] count;
      logic [31:0][7:0] unused_pad;
   } unused_t;

endpackage
`default_nettype wire

// file: src/seven_segment_scan_controller.sv
// Four-digit seven-segment scanner with interval timer, clock and registers.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "scan_regs.svh"

module seven_segment_scan_controller #(
   parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [7:0] segment_port_out,
   output logic [3:0] digit_select_port_out,
   output logic irq_out
);

   localparam int BLANK_CYC = (`BLANK_NS * `CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (`SETTLE_NS * `CLK_MHZ + 999) / 1000;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      scan_pkg::bus_out_t bus;
      logic [7:0] timer_ctrl;
      logic [7:0] clock_sel;
      logic [3:0] clock_div;
      logic [31:0] compare;
      logic match_status;
      logic [2:0] irq_status;
      logic [2:0] irq_enable;
      logic [1:0] irq_mask;
      logic [7:0] clock_mode;
      logic [7:0] alarm_ctrl;
      scan_pkg::clock_time_t now;
      logic [31:0] sec_count;
      logic [15:0] pre_count;
      logic [31:0] count;
      logic [3:0][7:0] seg_mem;
      scan_pkg::seq_state_t seq;
      logic [1:0] digit;
      logic [3:0] sel_pattern;
      logic [15:0] wait_count;
      logic [7:0] segment;
      logic [3:0] digit_sel;
      logic irq;
   } state_t;

   state_t cur;
   state_t next_cur;

   always_comb begin
      logic tick;
      logic match;
      logic sec_tick;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic hit;
      logic [2:0] set_irq;
      logic [2:0] clr_irq;
      logic [15:0] div_top;
      tick = 1'b0;
      match = 1'b0;
      sec_tick = 1'b0;
      wdata = 32'h00000000;
      rdata = 32'h00000000;
      hit = 1'b1;
      set_irq = 3'h0;
      clr_irq = 3'h0;
      div_top = 16'h0000;
      next_cur = cur;

      // ****************************************************************
      // Interval timer
      // ****************************************************************
      // oscillator select and prescaler
      div_top = 16'((32'h1 << cur.clock_div) - 32'h1);
      if (cur.timer_ctrl[`GATE_BIT] &&
          cur.clock_sel == `SEL_HIGH_SPEED_OSC) begin
         if (cur.pre_count >= div_top) begin
            next_cur.pre_count = 16'h0000;
            tick = 1'b1;
         end else begin
            next_cur.pre_count = cur.pre_count + 16'h0001;
         end
      end
      // width chosen by control bit 6
      if (tick) begin
         if (cur.timer_ctrl[`MODE32_BIT]) begin
            match = cur.count >= cur.compare;
         end else begin
            match = cur.count[15:0] >= cur.compare[15:0];
         end
         next_cur.count = match ? 32'h00000000 : cur.count + 32'h00000001;
      end
      if (match && !cur.irq_mask[0]) begin
         set_irq[`IRQ_TIMER_BIT] = 1'b1;
      end

      // ****************************************************************
      // Real-time clock
      // ****************************************************************
      if (cur.sec_count >= 32'(SECOND_CYCLES - 1)) begin
         next_cur.sec_count = 32'h00000000;
         sec_tick = 1'b1;
      end else begin
         next_cur.sec_count = cur.sec_count + 32'h00000001;
      end
      if (sec_tick) begin
         next_cur.now.second = cur.now.second + 6'h01;
         if (cur.now.second == 6'h3B) begin
            next_cur.now.second = 6'h00;
            next_cur.now.minute = cur.now.minute + 6'h01;
            if (cur.now.minute == 6'h3B) begin
               next_cur.now.minute = 6'h00;
               if (cur.clock_mode[`CLOCK_24H_BIT]) begin
                  next_cur.now.hour = (cur.now.hour == 4'hB) ? 4'h0 :
                     cur.now.hour + 4'h1;
               end else begin
                  next_cur.now.hour = (cur.now.hour == 4'hC) ? 4'h1 :
                     cur.now.hour + 4'h1;
                  if (cur.now.hour == 4'hB) begin
                     next_cur.now.pm = ~cur.now.pm;
                  end
               end
               if (cur.alarm_ctrl[`ALARM_EN_BIT] &&
                   cur.alarm_ctrl[5:0] == (cur.now.minute + 6'h01) % 6'h3C) begin
                  set_irq[`IRQ_ALARM_BIT] = 1'b1;
               end
            end
         end
         if (cur.clock_mode[2:0] == `CLOCK_PERIOD_1S && !cur.irq_mask[1]) begin
            set_irq[`IRQ_CLOCK_BIT] = 1'b1;
         end
      end

      // ****************************************************************
      // Register bus
      // ****************************************************************
      next_cur.bus.awready = 1'b0;
      next_cur.bus.wready = 1'b0;
      next_cur.bus.arready = 1'b0;
      if (cur.bus.bvalid && s_axi_bready_in) begin
         next_cur.bus.bvalid = 1'b0;
      end
      if (cur.bus.rvalid && s_axi_rready_in) begin
         next_cur.bus.rvalid = 1'b0;
      end
      if (s_axi_awvalid_in && s_axi_wvalid_in && !cur.bus.bvalid &&
          !cur.bus.awready) begin
         next_cur.bus.awready = 1'b1;
         next_cur.bus.wready = 1'b1;
      end
      if (cur.bus.awready) begin
         for (int b = 0; b < 4; b++) begin
            wdata[8*b +: 8] = s_axi_wstrb_in[b] ? s_axi_wdata_in[8*b +: 8] :
               8'h00;
         end
         next_cur.bus.bvalid = 1'b1;
         next_cur.bus.bresp = `RESP_OKAY;
         case (s_axi_awaddr_in)
            `OFS_TIMER_CTRL: next_cur.timer_ctrl = wdata[7:0];
            `OFS_CLOCK_SEL: next_cur.clock_sel = wdata[7:0];
            `OFS_CLOCK_DIV: next_cur.clock_div = wdata[3:0];
            `OFS_COMPARE: next_cur.compare = wdata;
            // writing zero clears match only; the timer flag is left as it is
            `OFS_MATCH_STATUS: if (!wdata[0]) next_cur.match_status = 1'b0;
            `OFS_IRQ_STATUS: clr_irq = ~wdata[2:0];
            `OFS_IRQ_ENABLE: next_cur.irq_enable = wdata[2:0];
            `OFS_IRQ_MASK: next_cur.irq_mask = wdata[1:0];
            `OFS_CLOCK_MODE: next_cur.clock_mode = wdata[7:0];
            `OFS_ALARM_CTRL: next_cur.alarm_ctrl = wdata[7:0];
            `OFS_TIME: next_cur.now = wdata[16:0];
            default: begin
               if (s_axi_awaddr_in[7:4] == `OFS_SEG_BASE >> 4) begin
                  next_cur.seg_mem[s_axi_awaddr_in[3:2]] = wdata[7:0];
               end else begin
                  next_cur.bus.bresp = `RESP_SLVERR;
               end
            end
         endcase
      end
      if (s_axi_arvalid_in && !cur.bus.rvalid && !cur.bus.arready) begin
         next_cur.bus.arready = 1'b1;
      end
      if (cur.bus.arready) begin
         case (s_axi_araddr_in)
            `OFS_TIMER_CTRL: rdata = {24'h000000, cur.timer_ctrl};
            `OFS_CLOCK_SEL: rdata = {24'h000000, cur.clock_sel};
            `OFS_CLOCK_DIV: rdata = {28'h0000000, cur.clock_div};
            `OFS_COMPARE: rdata = cur.compare;
            `OFS_MATCH_STATUS: rdata = {31'h00000000, cur.match_status};
            `OFS_IRQ_STATUS: rdata = {29'h00000000, cur.irq_status};
            `OFS_IRQ_ENABLE: rdata = {29'h00000000, cur.irq_enable};
            `OFS_IRQ_MASK: rdata = {30'h00000000, cur.irq_mask};
            `OFS_CLOCK_MODE: rdata = {24'h000000, cur.clock_mode};
            `OFS_ALARM_CTRL: rdata = {24'h000000, cur.alarm_ctrl};
            `OFS_TIME: rdata = {15'h0000, cur.now};
            default: begin
               hit = s_axi_araddr_in[7:4] == `OFS_SEG_BASE >> 4;
               rdata = hit ? {24'h000000, cur.seg_mem[s_axi_araddr_in[3:2]]} :
                  32'h00000000;
            end
         endcase
         next_cur.bus.rvalid = 1'b1;
         next_cur.bus.rdata = rdata;
         next_cur.bus.rresp = hit ? `RESP_OKAY : `RESP_SLVERR;
      end

      // ****************************************************************
      // Scan sequencer
      // ****************************************************************
      // An event that lands while a digit is still in progress is dropped;
      // the 256 us reset period dwarfs the scan, so it only happens on tiny compares.
      if (match) begin
         next_cur.match_status = 1'b1;
      end
      case (cur.seq)
         scan_pkg::SEQ_IDLE: begin
            if (set_irq[`IRQ_TIMER_BIT]) begin
               next_cur.seq = scan_pkg::SEQ_CLEAR;
            end
         end
         scan_pkg::SEQ_CLEAR: begin
            // clear match and blank all digits in the same cycle
            if (!match) begin
               next_cur.match_status = 1'b0;
            end
            next_cur.digit_sel = `DIGIT_ALL_OFF;
            next_cur.wait_count = 16'(BLANK_CYC - 1);
            next_cur.seq = scan_pkg::SEQ_BLANK;
         end
         scan_pkg::SEQ_BLANK: begin
            next_cur.wait_count = cur.wait_count - 16'h0001;
            if (cur.wait_count == 16'h0000) begin
               next_cur.seq = scan_pkg::SEQ_DATA;
            end
         end
         scan_pkg::SEQ_DATA: begin
            // segment bit 7 is A, bit 0 the point
            next_cur.segment = cur.seg_mem[cur.digit];
            next_cur.wait_count = 16'(SETTLE_CYC - 1);
            next_cur.seq = scan_pkg::SEQ_SETTLE;
         end
         scan_pkg::SEQ_SETTLE: begin
            next_cur.wait_count = cur.wait_count - 16'h0001;
            if (cur.wait_count == 16'h0000) begin
               next_cur.seq = scan_pkg::SEQ_SELECT;
            end
         end
         scan_pkg::SEQ_SELECT: begin
            // one low select line at a time
            // digit 0 sits on select bit 3
            next_cur.digit_sel = cur.sel_pattern;
            // advance, wrap to the start values
            if (cur.digit == 2'h3) begin
               next_cur.digit = 2'h0;
               next_cur.sel_pattern = `DIGIT_SEL_INIT;
            end else begin
               next_cur.digit = cur.digit + 2'h1;
               next_cur.sel_pattern = {1'b1, cur.sel_pattern[3:1]};
            end
            next_cur.seq = scan_pkg::SEQ_IDLE;
         end
         default: next_cur.seq = scan_pkg::SEQ_IDLE;
      endcase

      // Hardware set wins over a software clear in the same cycle.
      next_cur.irq_status = (cur.irq_status & ~clr_irq) | set_irq;
      next_cur.irq = |(next_cur.irq_status & next_cur.irq_enable);
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur <= '0;
         cur.compare <= `COMPARE_RESET;
         cur.irq_mask <= 2'h3;
         cur.now.hour <= 4'hC;
         cur.sel_pattern <= `DIGIT_SEL_INIT;
         cur.digit_sel <= `DIGIT_ALL_OFF;
         cur.seq <= scan_pkg::SEQ_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // ports come straight from the state flops
   assign s_axi_awready_out = cur.bus.awready;
   assign s_axi_wready_out = cur.bus.wready;
   assign s_axi_bvalid_out = cur.bus.bvalid;
   assign s_axi_bresp_out = cur.bus.bresp;
   assign s_axi_arready_out = cur.bus.arready;
   assign s_axi_rvalid_out = cur.bus.rvalid;
   assign s_axi_rresp_out = cur.bus.rresp;
   assign s_axi_rdata_out = cur.bus.rdata;
   assign segment_port_out = cur.segment;
   assign digit_select_port_out = cur.digit_sel;
   assign irq_out = cur.irq;

endmodule
`default_nettype wire

// file: verification/led_indicator_model.sv
// Behavioural four-digit common-cathode indicator facing the scanner.
`timescale 1ns/1ns
`default_nettype none
module led_indicator_model (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] segment_in,
   input wire logic [3:0] select_n_in,
   output logic [3:0][7:0] lit_out
);
   // low cathode lights
   // A digit shows the segments seen while its cathode line is low.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lit_out <= '0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (!select_n_in[k]) begin
               lit_out[3 - k] <= segment_in;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/scan_checker.sv
// Port-level assertions for the seven-segment scan controller.
`timescale 1ns/1ns
`default_nettype none
module scan_checker #(
   parameter int SECOND_CYCLES = 100
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rready_in,
   input wire logic [7:0] segment_port_out,
   input wire logic [3:0] digit_select_port_out
);
   // ****************************************************************
   // Helper counters
   // ****************************************************************
   // Ages saturate so a long idle spell cannot wrap into a false pass.
   logic [3:0] last_sel;
   logic [8:0] seg_age;
   logic [8:0] off_age;
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         last_sel <= 4'hE;
         seg_age <= 9'h000;
         off_age <= 9'h000;
      end else begin
         if (digit_select_port_out != 4'hF) begin
            last_sel <= digit_select_port_out;
            off_age <= 9'h000;
         end else if (off_age != 9'h1FF) begin
            off_age <= off_age + 9'h001;
         end
         if ($changed(segment_port_out)) begin
            seg_age <= 9'h000;
         end else if (seg_age != 9'h1FF) begin
            seg_age <= seg_age + 9'h001;
         end
      end
   end
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   a_select_valid: assert property (
      digit_select_port_out inside {4'h7, 4'hB, 4'hD, 4'hE, 4'hF})
      else $error("more than one digit selected");
   a_select_from_off: assert property (
      $changed(digit_select_port_out) && digit_select_port_out != 4'hF
      |-> $past(digit_select_port_out) == 4'hF)
      else $error("digit selected without blanking first");
   a_select_rotate: assert property (
      $past(digit_select_port_out) == 4'hF && digit_select_port_out != 4'hF
      |-> digit_select_port_out == {last_sel[0], last_sel[3:1]})
      else $error("digit select out of order");
   a_settle_wait: assert property (
      $past(digit_select_port_out) == 4'hF && digit_select_port_out != 4'hF
      |-> seg_age >= 9'h078)
      else $error("digit selected before data settled");
   a_blank_wait: assert property (
      $changed(segment_port_out) |-> off_age >= 9'h0F0)
      else $error("segment data changed before blanking ended");
   a_seg_when_off: assert property (
      $changed(segment_port_out) |-> digit_select_port_out == 4'hF
      && $past(digit_select_port_out) == 4'hF)
      else $error("segment data changed while a digit was lit");
   a_write_answer: assert property (
      s_axi_awready_out |-> s_axi_wready_out
      ##1 (s_axi_bvalid_out && !s_axi_awready_out))
      else $error("write response not given after acceptance");
   a_read_answer: assert property (
      s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read data not given after acceptance");
   a_resp_hold: assert property (
      s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped before taken");
   a_read_hold: assert property (
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
      && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
      else $error("read data dropped before taken");
   a_unmapped_read: assert property (
      s_axi_arvalid_in && s_axi_araddr_in >= 8'h50 && !s_axi_arready_out
      && !s_axi_rvalid_out |-> ##2 (s_axi_rvalid_out
      && s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h00000000))
      else $error("unmapped read not refused");
endmodule
bind seven_segment_scan_controller scan_checker #(
   .SECOND_CYCLES(SECOND_CYCLES)
) i_checker (
   .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
   .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
   .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rready_in(s_axi_rready_in),
   .segment_port_out(segment_port_out),
   .digit_select_port_out(digit_select_port_out)
);
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the seven-segment scan controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst_n, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, irq;
   logic [7:0] awa, ara, seg;
   logic [31:0] wd, rdat, got, t;
   logic [3:0] ws, sel;
   logic [1:0] bresp, rresp, resp;
   logic [3:0][7:0] lit;
   logic [7:0] pat [4];
   logic [7:0] offs [6] = '{8'h0C, 8'h1C, 8'h00, 8'h04, 8'h08, 8'h24};
   logic [31:0] rvals [6] = '{32'hF9FF, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
   int seed, miscompares, compares, cycles, gap;
   seven_segment_scan_controller #(.SECOND_CYCLES(100)) i_dut (
      .ref_clk_in(clk), .arst_n_in(rst_n), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
      .segment_port_out(seg), .digit_select_port_out(sel), .irq_out(irq));
   led_indicator_model i_leds (.ref_clk_in(clk), .arst_n_in(rst_n),
      .segment_in(seg), .select_n_in(sel), .lit_out(lit));
   function automatic logic [31:0] tm(logic pm, int h, int m, int s);
      return {15'h0, pm, 4'(h), 6'(m), 6'(s)};
   endfunction
   // Responses are taken one cycle late so the hold logic is exercised.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do @(posedge clk); while (awr !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      @(posedge clk);
      br <= 1'b1;
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      @(posedge clk);
      rr <= 1'b1;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b0;
      got = rdat;
      resp = rresp;
   endtask
   task automatic check_word(input string what, input logic [31:0] exp,
         input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_flag(input string what, input logic exp,
         input logic seen);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask
   // Counts cycles from one digit turning on to the next one turning on.
   task automatic wait_digit(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sel !== 4'hF && n < 5000);
      while (sel === 4'hF && n < 5000) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      {rst_n, awv, wv, br, arv, rr, awa, ara, wd} = '0;
      ws = 4'hF;
      seed = 96;
      cycles = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check_word("select at reset", 32'hF, 32'(sel));
      check_word("segments at reset", 32'h0, 32'(seg));
      for (int i = 0; i < 6; i++) begin
         rd(offs[i]);
         check_word("reset value", rvals[i], got);
      end
      $display("test reset values done");
      rd(8'h50 + 8'(($unsigned($random(seed)) % 44) * 4));
      check_word("unmapped read data", 32'h0, got);
      check_word("unmapped read resp", 32'h2, 32'(resp));
      wr(8'hFC, 32'($random(seed)));
      check_word("unmapped write", 32'h2, resp);
      $display("test unmapped done");
      for (int i = 0; i < 4; i++) begin
         pat[i] = 8'($random(seed));
         wr(8'h40 + 8'(4 * i), {24'h0, pat[i]});
      end
      wr(8'h04, 32'h1);
      wr(8'h0C, 32'h3FF);
      wr(8'h1C, 32'h2);
      wr(8'h00, 32'h41);
      for (int d = 0; d < 2; d++) begin
         wr(8'h08, d);
         repeat (3) wait_digit(gap);
         check_word("scan period", 32'h400 << d, gap);
      end
      repeat (4) wait_digit(gap);
      // The indicator latches the newest digit at this edge; look after it.
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         check_word("digit pattern", pat[i], lit[i]);
      end
      rd(8'h14);
      check_flag("timer flag", 1'b1, got[0]);
      rd(8'h10);
      check_word("match cleared", 32'h0, got);
      $display("test scan done");
      wr(8'h1C, 32'h3);
      wr(8'h14, 32'h0);
      t = sel;
      repeat (2100) @(posedge clk);
      check_word("select while masked", t, sel);
      rd(8'h14);
      check_word("masked status", 32'h0, got);
      $display("test masks done");
      wr(8'h20, 32'h2);
      wr(8'h24, 32'h0);
      wr(8'h18, 32'h7);
      // Unmask first, so a tick that lands right after the time write
      // still raises the clock flag that is checked below.
      wr(8'h1C, 32'h1);
      t = tm(1'b0, 11, 59, 59);
      wr(8'h28, t);
      got = t;
      for (int i = 0; i < 60 && got === t; i++) begin
         rd(8'h28);
      end
      check_word("time rollover", tm(1'b1, 12, 0, 0), got);
      rd(8'h14);
      check_word("clock status", 32'h2, got);
      check_flag("irq raised", 1'b1, irq);
      wr(8'h1C, 32'h3);
      wr(8'h14, 32'h0);
      rd(8'h14);
      check_word("cleared status", 32'h0, got);
      check_flag("irq cleared", 1'b0, irq);
      $display("test clock done");
      end_of_test();
   end
endmodule
`default_nettype wire
